// ===== hw/rds_sched.sv
`timescale 1ns/10ps
module rds_sched #(
  parameter int DW = 16,
  parameter int RD_LAT = 4,
  parameter int WR_LAT = 3,
  parameter int ACC_SPACING = 2,
  parameter int BUF_DEPTH = 2
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  // Request link pins
  input wire logic rq_clk,
  input wire logic [1:0] rq_kind,
  input wire logic [rds_pkg::RQ_W-1:0] rq_word,
  input wire logic [DW-1:0] dq_in,
  // Effective row-open command
  output logic open_fire,
  output logic [rds_pkg::BANK_W-1:0] open_bank,
  output logic [rds_pkg::ROW_W-1:0] open_row,
  // Effective access command
  output logic acc_fire,
  output logic acc_store,
  output logic [rds_pkg::BANK_W-1:0] acc_bank,
  output logic [rds_pkg::COL_W-1:0] acc_col,
  // Effective bank close
  output logic close_fire,
  output logic [rds_pkg::BANK_W-1:0] close_bank,
  // Effective refresh
  output logic ref_fire,
  output logic [1:0] ref_op,
  output logic [rds_pkg::REF_BANK_W-1:0] ref_bank,
  // Read data timing
  output logic read_data_start,
  // Write data to core
  output logic wdat_valid,
  input wire logic wdat_ready,
  output logic [DW-1:0] wdat_data,
  output logic wcap_ready,
  output logic wr_overrun
);
  localparam int BW = $clog2(ACC_SPACING + 1);

  if (RD_LAT < 1 || WR_LAT < 1 || ACC_SPACING < 1 || DW < 1) begin : g_param_chk
    $error("rds_sched: latencies, spacing and width must be at least 1");
  end

  function automatic logic [rds_pkg::WAIT_W-1:0] wait_of(input logic [1:0] kind,
      input logic [rds_pkg::RQ_W-1:0] w, input int ch);
    logic [rds_pkg::WAIT_W-1:0] r;
    r = '0;
    case (ch)
      rds_pkg::CH_OPEN: r = {1'b0, w[rds_pkg::OPEN_WAIT_BIT]};
      rds_pkg::CH_ACC: r = {1'b0, w[rds_pkg::ACC_WAIT_BIT]};
      rds_pkg::CH_CLS: r = w[rds_pkg::CLS_WAIT_LSB +: rds_pkg::WAIT_W];
      rds_pkg::CH_REF: r = w[rds_pkg::REF_WAIT_LSB +: rds_pkg::WAIT_W];
      default: r = '0;
    endcase
    return r;
  endfunction

  // Link pins pass two flip-flops; rq_clk rising edges mark request periods
  logic [rds_pkg::SYNC_N-1:0] rqc_q;
  logic rqc_prev_q;
  logic [1:0] kind_m_q, kind_s_q;
  logic [rds_pkg::RQ_W-1:0] word_m_q, word_s_q;
  logic [DW-1:0] dq_m_q, dq_s_q;
  logic tick;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rqc_q <= '0;
      rqc_prev_q <= 1'b0;
      kind_m_q <= '0;
      kind_s_q <= '0;
      word_m_q <= '0;
      word_s_q <= '0;
      dq_m_q <= '0;
      dq_s_q <= '0;
    end else if (ce) begin
      rqc_q <= {rqc_q[0], rq_clk};
      rqc_prev_q <= rqc_q[1];
      kind_m_q <= rq_kind;
      kind_s_q <= kind_m_q;
      word_m_q <= rq_word;
      word_s_q <= word_m_q;
      dq_m_q <= dq_in;
      dq_s_q <= dq_m_q;
    end
  end

  assign tick = ce && rqc_q[1] && !rqc_prev_q;

  // Decode: one packet may load both close and refresh channels
  logic new_v [rds_pkg::NUM_CH];
  logic [rds_pkg::WAIT_W-1:0] new_w [rds_pkg::NUM_CH];
  logic [rds_pkg::PL_W-1:0] new_p [rds_pkg::NUM_CH];

  always_comb begin
    for (int c = 0; c < rds_pkg::NUM_CH; c++) begin
      new_w[c] = wait_of(kind_s_q, word_s_q, c);
      new_v[c] = 1'b0;
      new_p[c] = '0;
    end
    new_v[rds_pkg::CH_OPEN] = (kind_s_q == rds_pkg::KIND_OPEN);
    new_p[rds_pkg::CH_OPEN] = rds_pkg::PL_W'(word_s_q[rds_pkg::BANK_LSB +:
        rds_pkg::BANK_W + rds_pkg::ROW_W]);
    new_v[rds_pkg::CH_ACC] = (kind_s_q == rds_pkg::KIND_ACCESS);
    new_p[rds_pkg::CH_ACC] = rds_pkg::PL_W'(word_s_q[rds_pkg::BANK_LSB +:
        rds_pkg::BANK_W + rds_pkg::COL_W + 1]);
    new_v[rds_pkg::CH_CLS] = (kind_s_q == rds_pkg::KIND_CLOSE) && word_s_q[rds_pkg::CLS_OP_BIT];
    new_p[rds_pkg::CH_CLS] = rds_pkg::PL_W'(word_s_q[rds_pkg::CLS_BANK_LSB +: rds_pkg::BANK_W]);
    new_v[rds_pkg::CH_REF] = (kind_s_q == rds_pkg::KIND_CLOSE) &&
        (word_s_q[rds_pkg::REF_OP_LSB +: 2] != rds_pkg::REF_NONE);
    new_p[rds_pkg::CH_REF] = {6'h00, word_s_q[rds_pkg::REF_OP_LSB +: 2],
        word_s_q[rds_pkg::REF_BANK_LSB +: rds_pkg::REF_BANK_W]};
  end

  // Per-channel countdown: stage k fires k+1 periods later
  logic pv_q [rds_pkg::NUM_CH][rds_pkg::PIPE_D];
  logic pv_d [rds_pkg::NUM_CH][rds_pkg::PIPE_D];
  logic [rds_pkg::PL_W-1:0] pp_q [rds_pkg::NUM_CH][rds_pkg::PIPE_D];
  logic [rds_pkg::PL_W-1:0] pp_d [rds_pkg::NUM_CH][rds_pkg::PIPE_D];
  logic fv_q [rds_pkg::NUM_CH];
  logic fv_d [rds_pkg::NUM_CH];
  logic [rds_pkg::PL_W-1:0] fp_q [rds_pkg::NUM_CH];
  logic [rds_pkg::PL_W-1:0] fp_d [rds_pkg::NUM_CH];

  // Channels are separate, so close and refresh waits stay apart
  always_comb begin
    pv_d = pv_q;
    pp_d = pp_q;
    for (int c = 0; c < rds_pkg::NUM_CH; c++) begin
      fv_d[c] = 1'b0;
      fp_d[c] = fp_q[c];
      if (tick) begin
        fv_d[c] = pv_q[c][0];
        fp_d[c] = pp_q[c][0];
        for (int k = 0; k < rds_pkg::PIPE_D - 1; k++) begin
          pv_d[c][k] = pv_q[c][k + 1];
          pp_d[c][k] = pp_q[c][k + 1];
        end
        pv_d[c][rds_pkg::PIPE_D - 1] = 1'b0;
        if (new_v[c] && new_w[c] == '0) begin
          fv_d[c] = 1'b1;
          fp_d[c] = new_p[c];
        end else if (new_v[c]) begin
          pv_d[c][new_w[c] - 2'h1] = 1'b1;
          pp_d[c][new_w[c] - 2'h1] = new_p[c];
        end
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int c = 0; c < rds_pkg::NUM_CH; c++) begin
        fv_q[c] <= 1'b0;
        fp_q[c] <= '0;
        for (int k = 0; k < rds_pkg::PIPE_D; k++) begin
          pv_q[c][k] <= 1'b0;
          pp_q[c][k] <= '0;
        end
      end
    end else if (ce) begin
      fv_q <= fv_d;
      fp_q <= fp_d;
      pv_q <= pv_d;
      pp_q <= pp_d;
    end
  end

  assign open_fire = fv_q[rds_pkg::CH_OPEN];
  assign open_bank = fp_q[rds_pkg::CH_OPEN][rds_pkg::BANK_LSB +: rds_pkg::BANK_W];
  assign open_row = fp_q[rds_pkg::CH_OPEN][rds_pkg::ROW_LSB +: rds_pkg::ROW_W];
  assign acc_fire = fv_q[rds_pkg::CH_ACC];
  assign acc_store = fp_q[rds_pkg::CH_ACC][rds_pkg::PL_STORE_BIT];
  assign acc_bank = fp_q[rds_pkg::CH_ACC][rds_pkg::BANK_LSB +: rds_pkg::BANK_W];
  assign acc_col = fp_q[rds_pkg::CH_ACC][rds_pkg::COL_LSB +: rds_pkg::COL_W];
  assign close_fire = fv_q[rds_pkg::CH_CLS];
  assign close_bank = fp_q[rds_pkg::CH_CLS][rds_pkg::BANK_W-1:0];
  assign ref_fire = fv_q[rds_pkg::CH_REF];
  assign ref_op = fp_q[rds_pkg::CH_REF][rds_pkg::PL_REFOP_LSB +: 2];
  assign ref_bank = fp_q[rds_pkg::CH_REF][rds_pkg::REF_BANK_W-1:0];

  // Latency lines count periods from the effective access
  logic [RD_LAT-1:0] rdp_q, rdp_d;
  logic [WR_LAT-1:0] wrp_q, wrp_d;
  logic rd_go_q, rd_go_d;
  logic acc_now, store_now, wr_start;

  assign acc_now = fv_d[rds_pkg::CH_ACC];
  assign store_now = fp_d[rds_pkg::CH_ACC][rds_pkg::PL_STORE_BIT];
  assign wr_start = tick && wrp_q[0];

  always_comb begin
    rdp_d = rdp_q;
    wrp_d = wrp_q;
    rd_go_d = 1'b0;
    if (tick) begin
      rd_go_d = rdp_q[0];
      rdp_d = rdp_q >> 1;
      wrp_d = wrp_q >> 1;
      if (acc_now && !store_now) rdp_d[RD_LAT-1] = 1'b1;
      if (acc_now && store_now) wrp_d[WR_LAT-1] = 1'b1;
    end
  end

  // Write burst capture: one word per period for the packet length
  rds_pkg::rds_cap_e cap_q, cap_d;
  logic [BW-1:0] beat_q, beat_d;
  logic cap_push;

  always_comb begin
    cap_d = cap_q;
    beat_d = beat_q;
    cap_push = 1'b0;
    case (cap_q)
      rds_pkg::RDS_CAP_IDLE: begin
        if (wr_start) begin
          cap_push = 1'b1;
          beat_d = BW'(ACC_SPACING - 1);
          cap_d = (ACC_SPACING > 1) ? rds_pkg::RDS_CAP_BURST : rds_pkg::RDS_CAP_IDLE;
        end
      end
      rds_pkg::RDS_CAP_BURST: begin
        if (wr_start) begin
          // Back-to-back stores restart the burst
          cap_push = 1'b1;
          beat_d = BW'(ACC_SPACING - 1);
        end else if (tick) begin
          cap_push = 1'b1;
          beat_d = beat_q - BW'(1);
          if (beat_q == BW'(1)) cap_d = rds_pkg::RDS_CAP_IDLE;
        end
      end
      default: cap_d = rds_pkg::RDS_CAP_IDLE;
    endcase
  end

  logic ovr_q, ovr_d;
  assign ovr_d = cap_push && !wcap_ready;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdp_q <= '0;
      wrp_q <= '0;
      rd_go_q <= 1'b0;
      cap_q <= rds_pkg::RDS_CAP_IDLE;
      beat_q <= '0;
      ovr_q <= 1'b0;
    end else if (ce) begin
      rdp_q <= rdp_d;
      wrp_q <= wrp_d;
      rd_go_q <= rd_go_d;
      cap_q <= cap_d;
      beat_q <= beat_d;
      ovr_q <= ovr_d;
    end
  end

  assign read_data_start = rd_go_q;
  assign wr_overrun = ovr_q;

  // Buffer absorbs a core stall so captured words survive
  rds_stream_if #(.W(DW)) cap_s ();
  rds_stream_if #(.W(DW)) core_s ();

  assign cap_s.valid = cap_push;
  assign cap_s.data = dq_s_q;
  assign wcap_ready = cap_s.ready;
  assign wdat_valid = core_s.valid;
  assign wdat_data = core_s.data;
  assign core_s.ready = wdat_ready;

  rds_wbuf #(.W(DW), .DEPTH(BUF_DEPTH)) u_wbuf (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .in_s(cap_s),
    .out_s(core_s)
  );
endmodule // rds_sched

// ===== hw/rds_wbuf.sv
`timescale 1ns/10ps
module rds_wbuf #(
  parameter int W = 16,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  // Streams
  rds_stream_if.snk in_s,
  rds_stream_if.src out_s
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  // Pointers wrap by overflow, so only powers of two work
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_chk
    $error("rds_wbuf: DEPTH must be a power of two >= 2");
  end

  logic [W-1:0] mem_q [DEPTH];
  logic [W-1:0] mem_d [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic push, pop;

  assign in_s.ready = (cnt_q != CW'(DEPTH));
  assign out_s.valid = (cnt_q != '0);
  assign out_s.data = mem_q[rd_q];
  assign push = in_s.valid && in_s.ready && ce;
  assign pop = out_s.valid && out_s.ready && ce;

  always_comb begin
    mem_d = mem_q;
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wr_q] = in_s.data;
      wr_d = wr_q + AW'(1);
    end
    if (pop) begin
      rd_d = rd_q + AW'(1);
    end
    if (push && !pop) begin
      cnt_d = cnt_q + CW'(1);
    end else if (pop && !push) begin
      cnt_d = cnt_q - CW'(1);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < DEPTH; i++) mem_q[i] <= '0;
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      mem_q <= mem_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end
endmodule // rds_wbuf

// ===== inc/rds_pkg.sv
package rds_pkg;
  localparam int RQ_W = 24;
  localparam int PL_W = 16;
  localparam int NUM_CH = 4;
  localparam int PIPE_D = 3;
  localparam int SYNC_N = 2;
  localparam int REQ_PERIOD_NS = 80;
  localparam int CLK_PERIOD_NS = 10;
  localparam int CLKS_PER_REQ = REQ_PERIOD_NS / CLK_PERIOD_NS;
  // Packet kinds on the request pins
  localparam logic [1:0] KIND_IDLE = 2'h0;
  localparam logic [1:0] KIND_OPEN = 2'h1;
  localparam logic [1:0] KIND_ACCESS = 2'h2;
  localparam logic [1:0] KIND_CLOSE = 2'h3;
  // Row-open and access fields
  localparam int BANK_LSB = 0;
  localparam int BANK_W = 3;
  localparam int ROW_LSB = 3;
  localparam int ROW_W = 12;
  localparam int OPEN_WAIT_BIT = 15;
  localparam int COL_LSB = 3;
  localparam int COL_W = 6;
  localparam int ACC_STORE_BIT = 9;
  localparam int ACC_WAIT_BIT = 10;
  // Row-close fields
  localparam int CLS_OP_BIT = 0;
  localparam int CLS_BANK_LSB = 1;
  localparam int CLS_WAIT_LSB = 4;
  localparam int REF_OP_LSB = 6;
  localparam int REF_BANK_LSB = 8;
  localparam int REF_BANK_W = 8;
  localparam int REF_WAIT_LSB = REF_BANK_LSB + 6;
  localparam int WAIT_W = 2;
  // Refresh opcodes
  localparam logic [1:0] REF_NONE = 2'h0;
  localparam logic [1:0] REF_BANK_CLOSE = 2'h1;
  localparam logic [1:0] REF_ALL = 2'h2;
  localparam logic [1:0] REF_INCR = 2'h3;
  // Delay channels
  localparam int CH_OPEN = 0;
  localparam int CH_ACC = 1;
  localparam int CH_CLS = 2;
  localparam int CH_REF = 3;
  // Payload layout: access store flag and refresh op above bank/column
  localparam int PL_STORE_BIT = 9;
  localparam int PL_REFOP_LSB = 8;
  typedef enum logic [0:0] {
    RDS_CAP_IDLE = 1'b0,
    RDS_CAP_BURST = 1'b1
  } rds_cap_e;
endpackage

// ===== inc/rds_stream_if.sv
`timescale 1ns/10ps
interface rds_stream_if #(parameter int W = 16);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ===== verification/rds_ctrl_model.sv
`timescale 1ns/10ps
module rds_ctrl_model (
  // Next packet from the bench
  input wire logic [1:0] nxt_kind,
  input wire logic [rds_pkg::RQ_W-1:0] nxt_word,
  input wire logic [15:0] nxt_dq,
  // Request and data pins
  output logic rq_clk,
  output logic [1:0] rq_kind,
  output logic [rds_pkg::RQ_W-1:0] rq_word,
  output logic [15:0] dq_in
);
  // Request clock runs free, off the system clock phase
  initial begin
    rq_clk = 1'b0;
    rq_kind = 2'h0;
    rq_word = 24'h0;
    dq_in = 16'h0;
    #3;
    forever #40 rq_clk = ~rq_clk;
  end
  // Fields move on the falling edge: a full half period of setup and hold
  // Idle periods toggle the word so stale fields never look valid
  always @(negedge rq_clk) begin
    rq_kind <= nxt_kind;
    rq_word <= (nxt_kind == rds_pkg::KIND_IDLE) ? ~rq_word : nxt_word;
    dq_in <= nxt_dq;
  end
endmodule // rds_ctrl_model

// ===== verification/rds_sched_sva.sv
`timescale 1ns/10ps
module rds_sched_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  // Request pins
  input wire logic rq_clk,
  input wire logic [1:0] rq_kind,
  input wire logic [rds_pkg::RQ_W-1:0] rq_word,
  // Effective commands
  input wire logic open_fire,
  input wire logic acc_fire,
  input wire logic close_fire,
  input wire logic ref_fire,
  input wire logic read_data_start,
  // Write data buffer
  input wire logic wdat_valid,
  input wire logic wdat_ready,
  input wire logic [15:0] wdat_data,
  input wire logic wcap_ready,
  input wire logic wr_overrun
);
  logic s1_q, s2_q, s3_q, tick, op_t, ac_t, cl_t, rf_t;
  logic [1:0] cw, rw;
  // Own synchroniser; windows allow one cycle of phase doubt
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else if (ce) begin
      s1_q <= rq_clk;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  assign tick = ce & s2_q & ~s3_q;
  assign op_t = tick && rq_kind == rds_pkg::KIND_OPEN;
  assign ac_t = tick && rq_kind == rds_pkg::KIND_ACCESS;
  assign cl_t = tick && rq_kind == rds_pkg::KIND_CLOSE && rq_word[rds_pkg::CLS_OP_BIT];
  assign rf_t = tick && rq_kind == rds_pkg::KIND_CLOSE
    && rq_word[rds_pkg::REF_OP_LSB +: 2] != rds_pkg::REF_NONE;
  assign cw = rq_word[rds_pkg::CLS_WAIT_LSB +: 2];
  assign rw = rq_word[rds_pkg::REF_WAIT_LSB +: 2];
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  open_now_a: assert property (op_t && !rq_word[15] |-> ##[0:2] open_fire)
    else $error("row open not on time");
  open_late_a: assert property (op_t && rq_word[15] |-> ##[8:10] open_fire)
    else $error("delayed row open not one period later");
  acc_late_a: assert property (ac_t && rq_word[10] |-> ##[8:10] acc_fire)
    else $error("delayed access not one period later");
  read_lat_a: assert property (ac_t && rq_word[10] && !rq_word[9]
    |-> ##[40:42] read_data_start)
    else $error("read start not timed from postponed access");
  close_now_a: assert property (cl_t && cw == 2'h0 |-> ##[0:2] close_fire)
    else $error("close without wait late");
  close_wait_a: assert property (cl_t && cw == 2'h3 |-> ##[24:26] close_fire)
    else $error("close wait of three wrong");
  ref_wait_a: assert property (rf_t && rw == 2'h2 |-> ##[16:18] ref_fire)
    else $error("refresh wait of two wrong");
  delay_split_a: assert property (cl_t && rf_t && cw == 2'h0 && rw != 2'h0
    |-> ##[0:2] close_fire && !ref_fire)
    else $error("refresh delay moved the close");
  wdat_hold_a: assert property (wdat_valid && !wdat_ready
    |=> wdat_valid && $stable(wdat_data))
    else $error("write word lost during stall");
  overrun_full_a: assert property (wr_overrun |-> !$past(wcap_ready))
    else $error("overrun without full buffer");
endmodule // rds_sched_sva
bind rds_sched rds_sched_sva u_sva (.clk, .sys_rst, .ce, .rq_clk, .rq_kind, .rq_word,
  .open_fire, .acc_fire, .close_fire, .ref_fire, .read_data_start, .wdat_valid,
  .wdat_ready, .wdat_data, .wcap_ready, .wr_overrun);

// ===== verification/rds_sched_tb.sv
`timescale 1ns/10ps
module rds_sched_tb;
  logic clk, sys_rst, ce, rq_clk, open_fire, acc_fire, acc_store, close_fire, ref_fire;
  logic read_data_start, wdat_valid, wdat_ready, wcap_ready, wr_overrun;
  logic [1:0] rq_kind, ref_op, nxt_kind;
  logic [23:0] rq_word, nxt_word;
  logic [15:0] dq_in, wdat_data, nxt_dq;
  logic [2:0] open_bank, acc_bank, close_bank;
  logic [11:0] open_row;
  logic [5:0] acc_col;
  logic [7:0] ref_bank;
  logic [31:0] pv [7][$];
  longint pt [7][$];
  int err_count = 0;
  int compares = 0;
  // Controller-side core timings in request periods; plain defaults
  localparam int T_CLS_OPN = 2;
  localparam int T_OPN_WR = 1;
  localparam int T_WR_CLS = 3;
  localparam int T_MIN_OPEN = 3;
  localparam int T_OPEN_MIN = (T_MIN_OPEN > T_OPN_WR + T_WR_CLS) ? T_MIN_OPEN : T_OPN_WR + T_WR_CLS;
  localparam int WR_WORDS = 2;
  localparam int RQP = rds_pkg::REQ_PERIOD_NS;
  rds_ctrl_model u_ctrl (.nxt_kind, .nxt_word, .nxt_dq, .rq_clk, .rq_kind, .rq_word, .dq_in);
  rds_sched DUT (.clk, .sys_rst, .ce, .rq_clk, .rq_kind, .rq_word, .dq_in, .open_fire,
    .open_bank, .open_row, .acc_fire, .acc_store, .acc_bank, .acc_col, .close_fire,
    .close_bank, .ref_fire, .ref_op, .ref_bank, .read_data_start, .wdat_valid,
    .wdat_ready, .wdat_data, .wcap_ready, .wr_overrun);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic rec(input int c, input logic [31:0] v);
    pv[c].push_back(v);
    pt[c].push_back($time);
  endtask
  task automatic clear();
    for (int i = 0; i < 7; i++) begin
      pv[i].delete();
      pt[i].delete();
    end
  endtask
  // One packet per request period
  task automatic send(input logic [1:0] k, input logic [23:0] w, input logic [15:0] d);
    @(posedge clk);
    nxt_kind <= k;
    nxt_word <= w;
    nxt_dq <= d;
    @(negedge rq_clk);
  endtask
  task automatic idle(input int n);
    repeat (n) send(rds_pkg::KIND_IDLE, 24'h0, 16'h5A5A);
  endtask
  always @(posedge clk) begin
    if (open_fire) rec(0, {open_bank, open_row});
    if (acc_fire) rec(1, {acc_store, acc_bank, acc_col});
    if (close_fire) rec(2, close_bank);
    if (ref_fire) rec(3, {ref_op, ref_bank});
    if (read_data_start) rec(4, 0);
    if (wr_overrun) rec(5, 0);
    if (wdat_valid && wdat_ready) rec(6, wdat_data);
  end
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #100000;
    err_count++;
    summarize();
  end
  initial begin
    // Clock enable held on: freezing is outside these tests
    ce = 1'b1;
    sys_rst = 1'b1;
    wdat_ready = 1'b1;
    nxt_kind = 2'h0;
    nxt_word = 24'h0;
    nxt_dq = 16'h0;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    idle(2);
    clear();
    send(rds_pkg::KIND_OPEN, {8'h00, 1'b1, 12'h123, 3'h2}, 16'h0);
    idle(1);
    send(rds_pkg::KIND_OPEN, {8'h00, 1'b0, 12'h456, 3'h3}, 16'h0);
    idle(2);
    check(pv[0].size(), 2);
    check(pv[0][0], {3'h2, 12'h123});
    check(pv[0][1], {3'h3, 12'h456});
    check(32'(pt[0][1] - pt[0][0]), 80);
    $display("test row open done");
    clear();
    send(rds_pkg::KIND_ACCESS, {13'h0, 1'b1, 1'b0, 6'h05, 3'h1}, 16'h0);
    idle(1);
    send(rds_pkg::KIND_ACCESS, {13'h0, 1'b0, 1'b0, 6'h09, 3'h4}, 16'h0);
    idle(7);
    check(pv[1][0], {1'b0, 3'h1, 6'h05});
    check(32'(pt[1][1] - pt[1][0]), 80);
    check(pv[4].size(), 2);
    check(32'(pt[4][0] - pt[1][0]), 320);
    $display("test access done");
    // Close and refresh on distinct banks, waits swept against each other
    for (int i = 0; i < 4; i++) begin
      clear();
      send(rds_pkg::KIND_CLOSE, {8'h00, 2'(3 - i), 6'(i + 4), 2'(1 + i % 3), 2'(i), 3'(i),
        1'b1}, 16'h0);
      idle(5);
      check(pv[2].size(), 1);
      check(pv[2][0], 32'(i));
      check(pv[3][0], {2'(1 + i % 3), 2'(3 - i), 6'(i + 4)});
      check(32'(pt[3][0] - pt[2][0]), 32'(80 * (3 - 2 * i)));
    end
    $display("test row close done");
    // Stalled receiver: second burst must be refused, first kept
    @(posedge clk);
    wdat_ready <= 1'b0;
    clear();
    send(rds_pkg::KIND_ACCESS, {13'h0, 1'b1, 1'b1, 6'h01, 3'h0}, 16'hA000);
    for (int p = 1; p < 9; p++) begin
      if (p == 3) send(rds_pkg::KIND_ACCESS, {13'h0, 1'b0, 1'b1, 6'h02, 3'h0},
        16'(16'hA000 + p));
      else send(rds_pkg::KIND_IDLE, 24'h0, 16'(16'hA000 + p));
    end
    check(pv[1].size(), 2);
    check(pv[1][0], {1'b1, 3'h0, 6'h01});
    check(wcap_ready, 0);
    check(wdat_valid, 1);
    check(pv[5].size(), 2);
    @(posedge clk);
    wdat_ready <= 1'b1;
    // Look before each popping edge, while the word still stands
    for (int k = 0; k < 2; k++) begin
      #1;
      check(wdat_data, 16'(16'hA004 + k));
      @(posedge clk);
    end
    #1;
    check(wdat_valid, 0);
    $display("test write data done");
    // Page miss, close, then page empty on one bank
    clear();
    send(rds_pkg::KIND_CLOSE, {18'h0, 2'h0, 3'h5, 1'b1}, 16'h0);
    idle(T_CLS_OPN - 1);
    send(rds_pkg::KIND_OPEN, {8'h00, 1'b0, 12'h0AA, 3'h5}, 16'h0);
    idle(T_OPN_WR - 1);
    send(rds_pkg::KIND_ACCESS, {13'h0, 1'b0, 1'b1, 6'h03, 3'h5}, 16'h0);
    idle(WR_WORDS - 1);
    send(rds_pkg::KIND_ACCESS, {13'h0, 1'b0, 1'b1, 6'h04, 3'h5}, 16'h0);
    idle(T_WR_CLS - 1);
    send(rds_pkg::KIND_CLOSE, {18'h0, 2'h0, 3'h5, 1'b1}, 16'h0);
    idle(T_CLS_OPN - 1);
    send(rds_pkg::KIND_OPEN, {8'h00, 1'b0, 12'h0BB, 3'h5}, 16'h0);
    idle(T_OPN_WR - 1);
    send(rds_pkg::KIND_ACCESS, {13'h0, 1'b0, 1'b1, 6'h05, 3'h5}, 16'h0);
    idle(6);
    check(pv[2].size(), 2);
    check(pv[1][0], {1'b1, 3'h5, 6'h03});
    check(32'(pt[0][0] - pt[2][0]), 32'(RQP * T_CLS_OPN));
    check(32'(pt[1][0] - pt[0][0]), 32'(RQP * T_OPN_WR));
    check(32'(pt[2][1] - pt[1][1]), 32'(RQP * T_WR_CLS));
    check(32'(pt[2][1] - pt[0][0] >= RQP * T_OPEN_MIN), 1);
    check(32'(pt[0][1] - pt[2][1]), 32'(RQP * T_CLS_OPN));
    check(32'(pt[1][2] - pt[0][1]), 32'(RQP * T_OPN_WR));
    check(pv[6].size(), 32'(3 * WR_WORDS));
    check(pv[5].size(), 0);
    $display("test write transactions done");
    summarize();
  end
endmodule // rds_sched_tb
